// file: ppc_map.svh
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

// Register indices; byte address on the bus is four times the index
`define PPC_IDX_ACTIVATE 8'h30
`define PPC_IDX_BASE_HIGH 8'h60
`define PPC_IDX_BASE_LOW 8'h61
`define PPC_IDX_IRQ_SEL 8'h70
`define PPC_IDX_DMA_SEL 8'h74
`define PPC_IDX_MODE 8'hF0
`define PPC_IDX_STATUS 8'hF8

// Reset values
`define PPC_RST_ACTIVATE 8'h01
`define PPC_RST_BASE_HIGH 8'h03
`define PPC_RST_BASE_LOW 8'h78
`define PPC_RST_IRQ_SEL 8'h07
`define PPC_RST_DMA_SEL 8'h04
`define PPC_RST_MODE 8'h3F

// Writable bit masks, reserved bits are zero
`define PPC_WMASK_ACTIVATE 8'h01
`define PPC_WMASK_BASE 8'hFF
`define PPC_WMASK_IRQ_SEL 8'h0F
`define PPC_WMASK_DMA_SEL 8'h07
`define PPC_WMASK_MODE 8'h7F

// Field positions
`define PPC_ACT_BIT 0
`define PPC_IRQ_MSB 3
`define PPC_DMA_OFF_BIT 2
`define PPC_THR_MSB 6
`define PPC_THR_LSB 3
`define PPC_MODE_MSB 2

// Base address limits
`define PPC_BASE_MIN 12'h100
`define PPC_BASE_MAX4 12'hFFC
`define PPC_BASE_MAX8 12'hFF8

`endif

// file: ppc_pkg.sv
package ppc_pkg;

    // Parallel port mode field codes
    typedef enum logic [2:0] {
        PPC_MODE_SPP = 3'h0,
        PPC_MODE_EPP19 = 3'h1,
        PPC_MODE_ECP = 3'h2,
        PPC_MODE_ECP_EPP19 = 3'h3,
        PPC_MODE_PRINTER = 3'h4,
        PPC_MODE_EPP17 = 3'h5,
        PPC_MODE_RSVD = 3'h6,
        PPC_MODE_ECP_EPP17 = 3'h7
    } ppc_mode_t;

    // One-hot register select
    typedef enum logic [6:0] {
        PPC_SEL_NONE = 7'b000_0000,
        PPC_SEL_ACT = 7'b000_0001,
        PPC_SEL_BHI = 7'b000_0010,
        PPC_SEL_BLO = 7'b000_0100,
        PPC_SEL_IRQ = 7'b000_1000,
        PPC_SEL_DMA = 7'b001_0000,
        PPC_SEL_MODE = 7'b010_0000,
        PPC_SEL_STAT = 7'b100_0000
    } ppc_sel_t;

    // AHB transfer types
    typedef enum logic [1:0] {
        PPC_HT_IDLE = 2'b00,
        PPC_HT_BUSY = 2'b01,
        PPC_HT_NONSEQ = 2'b10,
        PPC_HT_SEQ = 2'b11
    } ppc_htrans_t;

endpackage

// file: ppc_cfg_reg.sv
`timescale 1ns/10ps
module ppc_cfg_reg
    import ppc_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WMASK = 8'hFF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Write port
    input wire logic we,
    input wire logic [7:0] wdata,
    // Stored value
    output logic [7:0] q
);

    logic [7:0] val_q;

    // Masked bits never store, so reserved bits stay zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            val_q <= RESET_VAL & WMASK;
        end else if (we) begin
            val_q <= wdata & WMASK;
        end
    end

    assign q = val_q;

endmodule

// file: ppc_mode_decode.sv
`timescale 1ns/10ps
module ppc_mode_decode
    import ppc_pkg::*;
(
    // Configuration inputs
    input wire logic [2:0] mode,
    input wire logic global_mode_set_bit,
    input wire logic epp_aligned,
    // Decoded protocol enables
    output logic spp_en,
    output logic epp_en,
    output logic ecp_en,
    output logic printer_en,
    output logic epp_v17,
    output logic mode_reserved
);

    logic epp_req;

    // Decode only defined for the first mode set
    always_comb begin
        spp_en = 1'b0;
        epp_req = 1'b0;
        ecp_en = 1'b0;
        printer_en = 1'b0;
        epp_v17 = 1'b0;
        mode_reserved = 1'b0;
        if (!global_mode_set_bit) begin
            unique case (ppc_mode_t'(mode))
                PPC_MODE_SPP: spp_en = 1'b1;
                PPC_MODE_EPP19: begin
                    spp_en = 1'b1;
                    epp_req = 1'b1;
                end
                PPC_MODE_ECP: ecp_en = 1'b1;
                PPC_MODE_ECP_EPP19: begin
                    ecp_en = 1'b1;
                    epp_req = 1'b1;
                end
                PPC_MODE_PRINTER: printer_en = 1'b1;
                PPC_MODE_EPP17: begin
                    spp_en = 1'b1;
                    epp_req = 1'b1;
                    epp_v17 = 1'b1;
                end
                PPC_MODE_RSVD: mode_reserved = 1'b1;
                PPC_MODE_ECP_EPP17: begin
                    ecp_en = 1'b1;
                    epp_req = 1'b1;
                    epp_v17 = 1'b1;
                end
            endcase
        end
        // EPP withheld unless the base sits on eight bytes
        epp_en = epp_req & epp_aligned;
    end

endmodule

// file: ppc_regs.sv
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "ppc_map.svh"
// Notes on behaviour
// - Activation bit 0 gates port; resets active.
// - Base spans 100h to FFCh; four-byte base: no EPP.
// - Eight-byte base up to FF8h allows every mode.
// - Base bytes reset to 03h and 78h.
// - Interrupt select bits 3-0, resets 07h.
// - DMA codes 0-3 pick channel; 1xx disables.
// - Mode register: threshold 6-3, mode 2-0, 3Fh.
// - Codes 000-100 decode SPP, EPP1.9, ECP, printer.
// - 101 EPP1.7, 111 ECP+EPP1.7, 110 reserved.
module ppc_regs
    import ppc_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [11:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Global option input, same clock domain
    input wire logic GLOBAL_MODE_SET_BIT,
    // Port configuration outputs
    output logic PORT_ACTIVE,
    output logic [11:0] PORT_BASE,
    output logic BASE_VALID,
    output logic EPP_AVAILABLE,
    output logic [3:0] IRQ_SELECT,
    output logic DMA_ENABLE,
    output logic [1:0] DMA_CHANNEL,
    output logic [3:0] FIFO_THRESHOLD,
    // Decoded operating mode
    output logic MODE_SPP,
    output logic MODE_EPP,
    output logic MODE_ECP,
    output logic MODE_PRINTER,
    output logic MODE_EPP_V17,
    output logic MODE_RESERVED
);

    localparam int NREG = 6;

    // Reset values and writable masks per stored register
    localparam logic [7:0] RST_VAL [NREG] = '{
        `PPC_RST_ACTIVATE,
        `PPC_RST_BASE_HIGH,
        `PPC_RST_BASE_LOW,
        `PPC_RST_IRQ_SEL,
        `PPC_RST_DMA_SEL,
        `PPC_RST_MODE
    };
    localparam logic [7:0] WR_MASK [NREG] = '{
        `PPC_WMASK_ACTIVATE,
        `PPC_WMASK_BASE,
        `PPC_WMASK_BASE,
        `PPC_WMASK_IRQ_SEL,
        `PPC_WMASK_DMA_SEL,
        `PPC_WMASK_MODE
    };

    // Output reset values follow the register defaults, so these
    // configuration outputs hold steady across reset release
    localparam logic ACT_RST = RST_VAL[0][`PPC_ACT_BIT];
    localparam logic [11:0] BASE_RST = {RST_VAL[1][3:0], RST_VAL[2]};
    localparam logic [3:0] IRQ_RST = RST_VAL[3][`PPC_IRQ_MSB:0];
    localparam logic DMA_EN_RST = ~RST_VAL[4][`PPC_DMA_OFF_BIT];
    localparam logic [1:0] DMA_CH_RST = RST_VAL[4][1:0];
    localparam logic [3:0] THR_RST = RST_VAL[5][`PPC_THR_MSB:`PPC_THR_LSB];

    // Word address to one-hot select; used for writes and reads
    function automatic ppc_sel_t reg_decode(input logic [11:0] addr);
        logic [9:0] idx;
        idx = addr[11:2];
        if (addr[1:0] != 2'b00) begin
            reg_decode = PPC_SEL_NONE;
        end else if (idx == {2'b00, `PPC_IDX_ACTIVATE}) begin
            reg_decode = PPC_SEL_ACT;
        end else if (idx == {2'b00, `PPC_IDX_BASE_HIGH}) begin
            reg_decode = PPC_SEL_BHI;
        end else if (idx == {2'b00, `PPC_IDX_BASE_LOW}) begin
            reg_decode = PPC_SEL_BLO;
        end else if (idx == {2'b00, `PPC_IDX_IRQ_SEL}) begin
            reg_decode = PPC_SEL_IRQ;
        end else if (idx == {2'b00, `PPC_IDX_DMA_SEL}) begin
            reg_decode = PPC_SEL_DMA;
        end else if (idx == {2'b00, `PPC_IDX_MODE}) begin
            reg_decode = PPC_SEL_MODE;
        end else if (idx == {2'b00, `PPC_IDX_STATUS}) begin
            reg_decode = PPC_SEL_STAT;
        end else begin
            reg_decode = PPC_SEL_NONE;
        end
    endfunction

    // Bus pipeline state
    logic addr_valid;
    ppc_sel_t sel_d;
    logic wr_pend_q;
    ppc_sel_t wr_sel_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Stored register values
    logic [7:0] reg_q [NREG];
    logic [7:0] reg_view [NREG];
    logic [NREG-1:0] reg_we;

    // Derived configuration
    logic [11:0] base_w;
    logic base_in_range;
    logic base_aligned8;
    logic epp_aligned;
    logic port_on;
    logic [7:0] status_w;

    // Decoder results
    logic dec_spp;
    logic dec_epp;
    logic dec_ecp;
    logic dec_printer;
    logic dec_v17;
    logic dec_rsvd;

    // Registered outputs
    logic active_q;
    logic [11:0] base_q;
    logic base_valid_q;
    logic epp_avail_q;
    logic [3:0] irq_q;
    logic dma_en_q;
    logic [1:0] dma_ch_q;
    logic [3:0] thr_q;
    logic spp_q;
    logic epp_q;
    logic ecp_q;
    logic printer_q;
    logic v17_q;
    logic rsvd_q;

    // Address phase is taken only on a NONSEQ or SEQ with HREADY high
    assign addr_valid = HSEL & HREADY & HTRANS[1];
    assign sel_d = reg_decode(HADDR);

    // Write is captured in the address phase and applied in the data phase
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            wr_pend_q <= 1'b0;
            wr_sel_q <= PPC_SEL_NONE;
        end else if (HREADY) begin
            wr_pend_q <= addr_valid & HWRITE;
            wr_sel_q <= (addr_valid & HWRITE) ? sel_d : PPC_SEL_NONE;
        end
    end

    // Status register is read-only, so it never gets a write enable
    assign reg_we = {NREG{wr_pend_q}} & wr_sel_q[NREG-1:0];

    // One register slice per configuration byte
    generate
        for (genvar i = 0; i < NREG; i++) begin : g_reg
            ppc_cfg_reg #(
                .RESET_VAL(RST_VAL[i]),
                .WMASK(WR_MASK[i])
            ) u_reg (
                .clk(CLK),
                .reset(RESET),
                .we(reg_we[i]),
                .wdata(HWDATA[7:0]),
                .q(reg_q[i])
            );
            // A read right behind a write sees the byte being written
            assign reg_view[i] = reg_we[i] ? (HWDATA[7:0] & WR_MASK[i]) : reg_q[i];
        end
    endgenerate

    // Base address from the two bytes; upper nibble of high byte drops out
    assign base_w = {reg_q[1][3:0], reg_q[2]};

    // Range and alignment checks decide which modes the base permits
    // A nonzero upper nibble in the high byte makes the base invalid
    assign base_in_range = (base_w >= `PPC_BASE_MIN) &&
        (base_w <= `PPC_BASE_MAX4) && (base_w[1:0] == 2'b00) &&
        (reg_q[1][7:4] == 4'h0);
    assign base_aligned8 = (base_w[2:0] == 3'b000) &&
        (base_w <= `PPC_BASE_MAX8);
    assign epp_aligned = base_in_range & base_aligned8;

    // Activation bit gates every protocol enable except the reserved-code flag
    assign port_on = reg_q[0][`PPC_ACT_BIT];

    // Mode field decode under the global mode-set bit
    ppc_mode_decode u_dec (
        .mode(reg_q[5][`PPC_MODE_MSB:0]),
        .global_mode_set_bit(GLOBAL_MODE_SET_BIT),
        .epp_aligned(epp_aligned),
        .spp_en(dec_spp),
        .epp_en(dec_epp),
        .ecp_en(dec_ecp),
        .printer_en(dec_printer),
        .epp_v17(dec_v17),
        .mode_reserved(dec_rsvd)
    );

    // Live status byte, all bits from the block's own state
    assign status_w = {
        1'b0,
        dma_en_q,
        rsvd_q,
        ecp_q,
        epp_q,
        epp_avail_q,
        base_valid_q,
        active_q
    };

    // Read mux; unmapped and reserved positions give zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (sel_d)
            PPC_SEL_ACT: rdata_d[7:0] = reg_view[0];
            PPC_SEL_BHI: rdata_d[7:0] = reg_view[1];
            PPC_SEL_BLO: rdata_d[7:0] = reg_view[2];
            PPC_SEL_IRQ: rdata_d[7:0] = reg_view[3];
            PPC_SEL_DMA: rdata_d[7:0] = reg_view[4];
            PPC_SEL_MODE: rdata_d[7:0] = reg_view[5];
            PPC_SEL_STAT: rdata_d[7:0] = status_w;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data sampled in the address phase. A write still in its data
    // phase is forwarded above, so a write then a read back to back is safe;
    // only the status byte may still show the state before that write
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rdata_q <= 32'h0000_0000;
        end else if (addr_valid & ~HWRITE) begin
            rdata_q <= rdata_d;
        end
    end

    // Zero wait state slave, always OKAY
    assign HRDATA = rdata_q;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // Activation gate
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            active_q <= ACT_RST;
        end else begin
            active_q <= port_on;
        end
    end

    // Base address and its legality
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            base_q <= BASE_RST;
            base_valid_q <= 1'b0;
            epp_avail_q <= 1'b0;
        end else begin
            base_q <= base_w;
            base_valid_q <= base_in_range;
            epp_avail_q <= epp_aligned;
        end
    end

    // Interrupt line choice
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            irq_q <= IRQ_RST;
        end else begin
            irq_q <= reg_q[3][`PPC_IRQ_MSB:0];
        end
    end

    // DMA routing; any code with the top bit set means no DMA
    // Channel still follows the low bits when off; qualify it with the enable
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            dma_en_q <= DMA_EN_RST;
            dma_ch_q <= DMA_CH_RST;
        end else begin
            dma_en_q <= ~reg_q[4][`PPC_DMA_OFF_BIT];
            dma_ch_q <= reg_q[4][1:0];
        end
    end

    // ECP FIFO threshold
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            thr_q <= THR_RST;
        end else begin
            thr_q <= reg_q[5][`PPC_THR_MSB:`PPC_THR_LSB];
        end
    end

    // Mode enables; an inactive port offers no protocol at all
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            spp_q <= 1'b0;
            epp_q <= 1'b0;
            ecp_q <= 1'b0;
            printer_q <= 1'b0;
            v17_q <= 1'b0;
            rsvd_q <= 1'b0;
        end else begin
            spp_q <= dec_spp & port_on;
            epp_q <= dec_epp & port_on;
            ecp_q <= dec_ecp & port_on;
            printer_q <= dec_printer & port_on;
            v17_q <= dec_v17 & port_on;
            rsvd_q <= dec_rsvd;
        end
    end

    // Output drive
    assign PORT_ACTIVE = active_q;
    assign PORT_BASE = base_q;
    assign BASE_VALID = base_valid_q;
    assign EPP_AVAILABLE = epp_avail_q;
    assign IRQ_SELECT = irq_q;
    assign DMA_ENABLE = dma_en_q;
    assign DMA_CHANNEL = dma_ch_q;
    assign FIFO_THRESHOLD = thr_q;
    assign MODE_SPP = spp_q;
    assign MODE_EPP = epp_q;
    assign MODE_ECP = ecp_q;
    assign MODE_PRINTER = printer_q;
    assign MODE_EPP_V17 = v17_q;
    assign MODE_RESERVED = rsvd_q;

endmodule

// file: ppc_regs_monitor.sv
`timescale 1ns/10ps
module ppc_regs_monitor (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Bus
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // Port configuration
    input wire logic GLOBAL_MODE_SET_BIT,
    input wire logic PORT_ACTIVE,
    input wire logic [11:0] PORT_BASE,
    input wire logic BASE_VALID,
    input wire logic EPP_AVAILABLE,
    input wire logic MODE_SPP,
    input wire logic MODE_EPP,
    input wire logic MODE_ECP,
    input wire logic MODE_PRINTER,
    input wire logic MODE_EPP_V17,
    input wire logic MODE_RESERVED
);
    // One clock domain, checks quiet in reset
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    chk_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not ready or not okay");
    chk_upper_zero: assert property (HRDATA[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_rdata_hold: assert property (
        !$past(HSEL && HREADY && HTRANS[1] && !HWRITE) |-> $stable(HRDATA))
        else $error("read data moved without a read");
    chk_base_range: assert property (
        BASE_VALID |-> PORT_BASE >= 12'h100 && PORT_BASE[1:0] == 2'b00)
        else $error("base flagged valid out of range");
    chk_four_no_epp: assert property (PORT_BASE[2] |-> !EPP_AVAILABLE)
        else $error("epp offered on four byte base");
    chk_epp_aligned: assert property (
        EPP_AVAILABLE |-> BASE_VALID && PORT_BASE <= 12'hFF8)
        else $error("epp offered on bad base");
    chk_mode_epp: assert property (MODE_EPP |-> EPP_AVAILABLE && PORT_ACTIVE)
        else $error("epp mode without aligned active port");
    chk_inactive_off: assert property (!PORT_ACTIVE |->
        !(MODE_SPP || MODE_EPP || MODE_ECP || MODE_PRINTER || MODE_EPP_V17))
        else $error("mode enabled while port inactive");
    // Mode outputs lag the global bit by one edge
    chk_global_off: assert property ($past(GLOBAL_MODE_SET_BIT) |->
        !(MODE_SPP || MODE_EPP || MODE_ECP || MODE_PRINTER || MODE_EPP_V17 || MODE_RESERVED))
        else $error("mode enabled under global bit");
    chk_printer_alone: assert property (MODE_PRINTER |->
        !(MODE_SPP || MODE_EPP || MODE_ECP || MODE_EPP_V17))
        else $error("printer mode mixed with others");
    chk_reserved_alone: assert property (MODE_RESERVED |->
        !(MODE_SPP || MODE_EPP || MODE_ECP || MODE_PRINTER || MODE_EPP_V17))
        else $error("reserved code enabled a mode");
endmodule

// file: tb_ppc_regs.sv
`timescale 1ns/10ps
`include "ppc_map.svh"
module tb_ppc_regs import ppc_pkg::*;;
    // Expected {spp,epp,ecp,printer,v17,reserved} per mode code
    localparam logic [5:0] MT [8] = '{6'h20, 6'h30, 6'h08, 6'h18, 6'h04, 6'h32, 6'h01, 6'h1A};
    // Base cases {high,low,valid,epp}
    localparam logic [17:0] BT [6] = '{{8'h01, 8'h00, 2'b11}, {8'h0F, 8'hF8, 2'b11},
        {8'h0F, 8'hFC, 2'b10}, {8'h00, 8'hFC, 2'b00}, {8'h03, 8'h7A, 2'b00},
        {8'h13, 8'h78, 2'b00}};
    logic clk, reset, hsel, hwrite, hready, hresp, gms, act, bval, eppa, dmae;
    logic [11:0] haddr, base;
    logic [1:0] htrans, dmach;
    logic [31:0] hwdata, hrdata;
    logic [3:0] irq, thr;
    wire logic [5:0] modes;
    logic [2:0] c;
    int fail_count, check_count;

    ppc_regs dut (.CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .GLOBAL_MODE_SET_BIT(gms),
        .PORT_ACTIVE(act), .PORT_BASE(base), .BASE_VALID(bval), .EPP_AVAILABLE(eppa),
        .IRQ_SELECT(irq), .DMA_ENABLE(dmae), .DMA_CHANNEL(dmach), .FIFO_THRESHOLD(thr),
        .MODE_SPP(modes[5]), .MODE_EPP(modes[4]), .MODE_ECP(modes[3]),
        .MODE_PRINTER(modes[2]), .MODE_EPP_V17(modes[1]), .MODE_RESERVED(modes[0]));

    // Free running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask

    // Bounded wait for ready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            fail_count++;
            wrap_up();
        end
    endtask

    task automatic bus(logic wr, logic [7:0] idx, logic [7:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= PPC_HT_NONSEQ;
        haddr <= {2'b00, idx, 2'b00};
        hwrite <= wr;
        wait_rdy();
        htrans <= PPC_HT_IDLE;
        hsel <= 1'b0;
        hwdata <= {24'h0, wd};
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(logic [7:0] idx, logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, idx, d, r);
    endtask

    task automatic rd_chk(string nm, logic [7:0] idx, logic [7:0] e);
        logic [31:0] r;
        bus(1'b0, idx, 8'h00, r);
        check(nm, r, {24'h0, e});
    endtask

    // Derived outputs follow one edge after the register
    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    // Main sequence
    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = PPC_HT_IDLE;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        gms = 1'b0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd_chk("act", `PPC_IDX_ACTIVATE, 8'h01);
        rd_chk("bhi", `PPC_IDX_BASE_HIGH, 8'h03);
        rd_chk("blo", `PPC_IDX_BASE_LOW, 8'h78);
        rd_chk("irq", `PPC_IDX_IRQ_SEL, 8'h07);
        rd_chk("dma", `PPC_IDX_DMA_SEL, 8'h04);
        rd_chk("mode", `PPC_IDX_MODE, 8'h3F);
        settle();
        check("base", base, 12'h378);
        check("valid", {act, bval, eppa}, 3'b111);
        check("dma", {dmae, irq, thr}, 9'h077);
        check("modes", modes, 6'h1A);
        $display("test reset values done");
        wr(`PPC_IDX_ACTIVATE, 8'hFF);
        wr(`PPC_IDX_IRQ_SEL, 8'hFF);
        wr(`PPC_IDX_DMA_SEL, 8'hFF);
        wr(`PPC_IDX_MODE, 8'hFF);
        wr(8'hFF, 8'hFF);
        rd_chk("act", `PPC_IDX_ACTIVATE, 8'h01);
        rd_chk("irq", `PPC_IDX_IRQ_SEL, 8'h0F);
        rd_chk("dma", `PPC_IDX_DMA_SEL, 8'h07);
        rd_chk("mode", `PPC_IDX_MODE, 8'h7F);
        rd_chk("unmapped", 8'hFF, 8'h00);
        check("hresp", hresp, 1'b0);
        wr(`PPC_IDX_STATUS, 8'h00);
        rd_chk("status", `PPC_IDX_STATUS, 8'h1F);
        settle();
        check("thr", thr, 4'hF);
        $display("test reserved bits done");
        for (int i = 0; i < 6; i++) begin
            wr(`PPC_IDX_BASE_HIGH, BT[i][17:10]);
            wr(`PPC_IDX_BASE_LOW, BT[i][9:2]);
            settle();
            check("base", base, {BT[i][13:10], BT[i][9:2]});
            check("valid", {bval, eppa}, BT[i][1:0]);
            check("mode_epp", modes[4], BT[i][0]);
        end
        wr(`PPC_IDX_BASE_HIGH, 8'h03);
        $display("test base alignment done");
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            wr(`PPC_IDX_MODE, {2'b01, c, c});
            settle();
            check("modes", modes, MT[c]);
            check("thr", thr, {1'b1, c});
        end
        @(posedge clk);
        gms <= 1'b1;
        settle();
        check("global", modes, 6'h00);
        @(posedge clk);
        gms <= 1'b0;
        wr(`PPC_IDX_ACTIVATE, 8'h00);
        settle();
        check("inactive", {act, modes}, 7'h00);
        rd_chk("status", `PPC_IDX_STATUS, 8'h06);
        wr(`PPC_IDX_ACTIVATE, 8'h01);
        $display("test mode decode done");
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            wr(`PPC_IDX_DMA_SEL, {5'h00, c});
            settle();
            check("dma", {dmae, dmach}, {~c[2], c[1:0]});
        end
        wr(`PPC_IDX_IRQ_SEL, 8'hA5);
        settle();
        check("irq", irq, 4'h5);
        rd_chk("irq", `PPC_IDX_IRQ_SEL, 8'h05);
        $display("test dma and irq done");
        wrap_up();
    end
endmodule

bind ppc_regs ppc_regs_monitor mon (.CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .GLOBAL_MODE_SET_BIT(GLOBAL_MODE_SET_BIT), .PORT_ACTIVE(PORT_ACTIVE),
    .PORT_BASE(PORT_BASE), .BASE_VALID(BASE_VALID), .EPP_AVAILABLE(EPP_AVAILABLE),
    .MODE_SPP(MODE_SPP), .MODE_EPP(MODE_EPP), .MODE_ECP(MODE_ECP),
    .MODE_PRINTER(MODE_PRINTER), .MODE_EPP_V17(MODE_EPP_V17), .MODE_RESERVED(MODE_RESERVED));
